/* File: smp_defines.vh */
`ifndef SMP_DEFINES_VH
`define SMP_DEFINES_VH

// control word field positions
`define SMP_CTL_RATE_LO   0
`define SMP_CTL_RATE_HI   1
`define SMP_CTL_PHASE     2
`define SMP_CTL_POLARITY  3
`define SMP_CTL_MASTER    4
`define SMP_CTL_ENABLE    6
`define SMP_CTL_IRQ_EN    7

// reset values
`define SMP_CTL_RESET     8'h00
`define SMP_BYTE_RESET    8'h00

// bits per character, last bit index
`define SMP_BYTE_BITS     8
`define SMP_LAST_BIT      3'h7

// sck half period terminal counts, half period minus one in mclk cycles (divide by 2, 4, 16, 32)
`define SMP_HALF_DIV2     4'h0
`define SMP_HALF_DIV4     4'h1
`define SMP_HALF_DIV16    4'h7
`define SMP_HALF_DIV32    4'hF

`endif

/* File: smp_peer_model.sv */
`timescale 1ns/1ps
module smp_peer_model (
   // serial pins
   input wire       sck,
   input wire       sel_n,
   input wire       mosi,
   output reg       miso,
   // mode and data
   input wire       clock_polarity,
   input wire       clock_phase,
   input wire [7:0] tx_byte,
   output reg [7:0] rx_byte
);
   reg [7:0] sh;
   wire      c = sck ^ clock_polarity;
   initial miso = 1'h0;
   initial rx_byte = 8'h00;
   // load on select, first bit early
   always @(negedge sel_n) begin
      sh = tx_byte;
      if (!clock_phase)
         miso = tx_byte[7];
   end
   always @(posedge sel_n)
      miso = ~miso;
   always @(posedge c) if (!sel_n) begin
      if (clock_phase) begin
         miso = sh[7];
         sh = sh << 1;
      end else
         rx_byte = {rx_byte[6:0], mosi};
   end
   always @(negedge c) if (!sel_n) begin
      if (clock_phase)
         rx_byte = {rx_byte[6:0], mosi};
      else begin
         sh = sh << 1;
         miso = sh[7];
      end
   end
endmodule

/* File: smp_port.v */
// What this block does
// R1: external master holds select low per transaction
// R2: master with select low sets mode fault
// R3: phase 0: select gates clock, high between bytes
// R4: phase 1: select may stay low across bytes
// R5: master ignores select pin except fault check
// R6: one byte per eight sck cycles
// R7: polarity and phase pick four timings
// R8: master presents data half cycle before sampling
// R9: rate bits only matter in master role
// R10: miso input as master, output as slave
// R11: unselected slave releases miso
// R12: mosi output as master, input as slave
// R13: full duplex, received byte replaces sent
// R14: write during transfer discarded, sets collision
// R15: completion flag set after eight bits
// R16: master sck idles at polarity, eight clocks
// R17: slave shifts mosi, full byte to buffer
// R18: slave write loads shift register directly
// R19: enabled port drives its pins itself
// R20: master at most half internal clock
// R21: rate pair divides by 2, 4, 16, 32
// R22: mode fault clears enable and master bits
// R23: completion cleared by status read, data access
// R24: byte arriving with flag set is dropped
// R25: reset leaves port disabled, slave, flags clear
`timescale 1ns/1ps
`include "smp_defines.vh"

module smp_port (
   // clock and reset
   input  wire       mclk,
   input  wire       sys_rst,
   // control word write
   input  wire       ctrl_wr,
   input  wire [7:0] ctrl_wdata,
   // status read strobe
   input  wire       stat_rd,
   // data access strobes
   input  wire       data_wr,
   input  wire [7:0] data_wdata,
   input  wire       data_rd,
   // software visible state
   output reg  [7:0] port_control_reg,
   output reg  [7:0] port_data_reg,
   output reg        transfer_done_flag,
   output reg        write_collision_flag,
   output reg        mode_fault_flag,
   output reg        port_irq,
   // slave select pin, input only
   input  wire       ss_n_in,
   // serial clock pin
   input  wire       sck_in,
   output reg        sck_out,
   output reg        sck_oe_n,
   // master out slave in pin
   input  wire       mosi_in,
   output wire       mosi_out,
   output reg        mosi_oe_n,
   // master in slave out pin
   input  wire       miso_in,
   output wire       miso_out,
   output reg        miso_oe_n
);

   ////////////////////////////////////////////////////////////////////////
   // control fields and pin synchronisers

   wire       irq_en   = port_control_reg[`SMP_CTL_IRQ_EN];
   wire       enabled  = port_control_reg[`SMP_CTL_ENABLE];
   wire       is_mst   = port_control_reg[`SMP_CTL_MASTER];
   wire       polarity = port_control_reg[`SMP_CTL_POLARITY];
   wire       phase    = port_control_reg[`SMP_CTL_PHASE];
   wire [1:0] rate     = {port_control_reg[`SMP_CTL_RATE_HI],
                          port_control_reg[`SMP_CTL_RATE_LO]};

   wire [3:0] pins_sync;
   wire       ss_n_s = pins_sync[3];
   wire       sck_s  = pins_sync[2];
   wire       mosi_s = pins_sync[1];
   wire       miso_s = pins_sync[0];

   smp_sync #(
      .WIDTH    (4)
   ) u_sync (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in ({ss_n_in, sck_in, mosi_in, miso_in}),
      .sync_out (pins_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // shift engine state

   reg  [7:0] shift_reg;
   reg        sample_bit;
   reg        tx_bit;
   reg  [2:0] bit_cnt;
   reg        m_active;
   reg        in_byte;
   reg        sck_s_d;
   reg        done_seen;
   reg        write_collision_flag_seen;
   reg        mode_fault_flag_seen;

   wire       master_on = enabled & is_mst;
   wire       slave_on  = enabled & ~is_mst;

   // same register feeds both data pins, only one is enabled at a time
   assign mosi_out = tx_bit;
   assign miso_out = tx_bit;

   ////////////////////////////////////////////////////////////////////////
   // master clock generation

   wire       rate_tick;

   // R21: divider sets half period
   // R9: divider runs only as master
   // R20: fastest rate is half mclk
   smp_rate_div u_div (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .run     (m_active),
      .rate    (rate),
      .tick    (rate_tick)
   );

   // R16: leading edge leaves idle level
   wire m_lead  = m_active & rate_tick & (sck_out == polarity);
   wire m_trail = m_active & rate_tick & (sck_out != polarity);

   ////////////////////////////////////////////////////////////////////////
   // slave edge detection

   // R7: polarity acts as an inverter on sck
   wire sck_n   = sck_s ^ polarity;
   wire sck_n_d = sck_s_d ^ polarity;

   // R3: select gates the shift clock
   // R4: phase 1 keeps counting across bytes
   wire s_sel   = slave_on & ~ss_n_s;
   wire s_lead  = s_sel & sck_n & ~sck_n_d;
   wire s_trail = s_sel & ~sck_n & sck_n_d;

   wire lead    = m_lead | s_lead;
   wire trail   = m_trail | s_trail;
   // R10: master samples miso
   // R12: slave samples mosi
   wire rx_in   = is_mst ? miso_s : mosi_s;
   wire byte_end = trail & (bit_cnt == `SMP_LAST_BIT);

   ////////////////////////////////////////////////////////////////////////
   // busy, write acceptance and flag clears

   // R14: transfer window depends on role and phase
   wire busy = is_mst ? m_active :
               (phase ? in_byte : s_sel);

   // R23: writes are ignored until the status read after completion
   wire wr_gate   = transfer_done_flag & ~done_seen;
   wire wr_take   = data_wr & enabled & ~busy & ~wr_gate;
   wire write_collision_flag_set  = data_wr & enabled & busy;
   wire data_acc  = data_rd | data_wr;
   wire done_clr  = data_acc & done_seen;
   wire write_collision_flag_clr  = data_acc & write_collision_flag_seen;
   wire mode_fault_flag_clr  = ctrl_wr & mode_fault_flag_seen;
   // R2: own select low while master
   wire mode_fault_flag_set  = master_on & ~ss_n_s;

   wire next_done = byte_end | (transfer_done_flag & ~done_clr);
   wire next_write_collision_flag = write_collision_flag_set | (write_collision_flag & ~write_collision_flag_clr);
   wire next_mode_fault_flag = mode_fault_flag_set | (mode_fault_flag & ~mode_fault_flag_clr);

   ////////////////////////////////////////////////////////////////////////
   // control word

   // R22: fault drops enable and master
   // R25: disabled slave after reset
   always @(posedge mclk) begin
      if (sys_rst) begin
         port_control_reg <= `SMP_CTL_RESET;
      end else begin
         if (ctrl_wr)
            port_control_reg <= ctrl_wdata & 8'hDF;
         if (mode_fault_flag_set) begin
            port_control_reg[`SMP_CTL_ENABLE] <= 1'b0;
            port_control_reg[`SMP_CTL_MASTER] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shift register and bit timing

   always @(posedge mclk) begin
      if (sys_rst) begin
         shift_reg  <= `SMP_BYTE_RESET;
         sample_bit <= 1'b0;
         tx_bit     <= 1'b0;
         bit_cnt    <= 3'h0;
         m_active   <= 1'b0;
         in_byte    <= 1'b0;
         sck_s_d    <= 1'b1;
      end else begin
         sck_s_d <= sck_s;
         if (!enabled || mode_fault_flag_set) begin
            m_active <= 1'b0;
            in_byte  <= 1'b0;
            bit_cnt  <= 3'h0;
         end else if (wr_take) begin
            // R18: write goes straight to shift register
            shift_reg <= data_wdata;
            tx_bit    <= data_wdata[7];
            bit_cnt   <= 3'h0;
            // R16: master write starts eight clocks
            m_active  <= is_mst;
         end else if (slave_on && ss_n_s) begin
            // R3: select high ends the character
            bit_cnt <= 3'h0;
            in_byte <= 1'b0;
         end else begin
            if (lead) begin
               in_byte <= 1'b1;
               if (phase)
                  // R8: phase 1 puts bit out on leading edge
                  tx_bit <= shift_reg[7];
               else
                  sample_bit <= rx_in;
            end
            if (trail) begin
               // R13: received bits replace sent bits
               // R10: most significant bit first
               if (phase) begin
                  shift_reg <= {shift_reg[6:0], rx_in};
               end else begin
                  shift_reg <= {shift_reg[6:0], sample_bit};
                  // R8: next bit half a cycle ahead
                  tx_bit    <= shift_reg[6];
               end
               bit_cnt <= bit_cnt + 3'h1;
            end
            // R6: eight clocks then stop
            if (byte_end) begin
               m_active <= 1'b0;
               in_byte  <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // master sck pin level

   // R16: idle at polarity, toggle each half period
   always @(posedge mclk) begin
      if (sys_rst)
         sck_out <= 1'b0;
      else if (!m_active)
         sck_out <= polarity;
      else if (rate_tick)
         sck_out <= ~sck_out;
   end

   ////////////////////////////////////////////////////////////////////////
   // read buffer

   // R17: full byte copied to read buffer
   // R24: overrun byte is lost
   always @(posedge mclk) begin
      if (sys_rst) begin
         port_data_reg <= `SMP_BYTE_RESET;
      end else if (byte_end && (!transfer_done_flag || done_clr)) begin
         if (phase)
            port_data_reg <= {shift_reg[6:0], rx_in};
         else
            port_data_reg <= {shift_reg[6:0], sample_bit};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags, set wins over clear

   always @(posedge mclk) begin
      if (sys_rst) begin
         transfer_done_flag   <= 1'b0;
         write_collision_flag <= 1'b0;
         mode_fault_flag      <= 1'b0;
         done_seen            <= 1'b0;
         write_collision_flag_seen            <= 1'b0;
         mode_fault_flag_seen            <= 1'b0;
         port_irq             <= 1'b0;
      end else begin
         // R15: completion after last bit
         transfer_done_flag   <= next_done;
         // R14: collision write flagged
         write_collision_flag <= next_write_collision_flag;
         // R2: fault flag held until cleared
         mode_fault_flag      <= next_mode_fault_flag;
         // R23: status read arms the clear
         done_seen <= next_done & (done_seen | (stat_rd & transfer_done_flag))
                      & ~byte_end;
         write_collision_flag_seen <= next_write_collision_flag & (write_collision_flag_seen | (stat_rd & write_collision_flag))
                      & ~write_collision_flag_set;
         mode_fault_flag_seen <= next_mode_fault_flag & (mode_fault_flag_seen | (stat_rd & mode_fault_flag))
                      & ~mode_fault_flag_set;
         // R22: interrupt when enabled
         port_irq  <= irq_en & (next_done | next_mode_fault_flag);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin direction

   // R19: port takes over pin directions
   // R10: miso driven only by slave
   // R11: unselected slave releases miso
   // R5: select pin never driven here
   always @(posedge mclk) begin
      if (sys_rst) begin
         sck_oe_n  <= 1'b1;
         mosi_oe_n <= 1'b1;
         miso_oe_n <= 1'b1;
      end else begin
         sck_oe_n  <= ~(master_on & ~mode_fault_flag_set);
         mosi_oe_n <= ~(master_on & ~mode_fault_flag_set);
         miso_oe_n <= ~(slave_on & ~ss_n_s);
      end
   end

endmodule

/* File: smp_port_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin \
   checks_done++; \
   if ((sn) !== (ex)) begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", nm, ex, sn); \
   end \
end
module smp_port_bench;
   logic       mclk = 1'h0;
   logic       sys_rst, ctrl_wr, stat_rd, data_wr, data_rd, ss_n_in;
   logic [7:0] ctrl_wdata, data_wdata, tx, ptx, got, p_tx;
   logic       m_sck, m_mosi, p_sel_n, clock_polarity, clock_phase, done_q, sck_q;
   logic [8:0] q[$];
   logic [8:0] note;
   int         num_errors, checks_done, gcnt, gap, k, j;
   int         hv[4] = '{1, 2, 8, 16};
   wire  [7:0] port_control_reg, port_data_reg, p_rx;
   wire        transfer_done_flag, write_collision_flag, mode_fault_flag;
   wire        port_irq, sck_out, sck_oe_n, mosi_out, mosi_oe_n;
   wire        miso_out, miso_oe_n, p_miso;
   wire        sck_in = sck_oe_n ? m_sck : sck_out;
   wire        mosi_in = mosi_oe_n ? m_mosi : mosi_out;
   wire        miso_in = miso_oe_n ? p_miso : miso_out;
   smp_port dut_u (.*);
   smp_peer_model peer_u (.sck(sck_in), .sel_n(p_sel_n), .mosi(mosi_in),
      .miso(p_miso), .clock_polarity(clock_polarity), .clock_phase(clock_phase), .tx_byte(p_tx),
      .rx_byte(p_rx));
   // clock
   always #4 mclk = ~mclk;
   task automatic results();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // one strobe: 0 status, 1 data read, 2 data write, 3 control
   task automatic op(input int w, input [7:0] d);
      ctrl_wdata = d;
      data_wdata = d;
      {stat_rd, data_rd, data_wr, ctrl_wr} = {w == 0, w == 1, w == 2, w == 3};
      @(negedge mclk);
      {stat_rd, data_rd, data_wr, ctrl_wr} = 4'h0;
      @(negedge mclk);
   endtask
   task automatic wait_for(input logic f);
      int n;
      n = 0;
      while ((f ? mode_fault_flag : transfer_done_flag) !== 1'h1) begin
         n++;
         if (n > 3000) begin
            num_errors++;
            $display("Error flag wait expected set seen timeout");
            results();
         end
         @(negedge mclk);
      end
   endtask
   // master exchange with the peer, optional colliding write
   task automatic mxfer(input logic chk, input logic coll);
      tx = 8'($urandom);
      p_tx = 8'($urandom);
      p_sel_n = 1'h0;
      repeat (3) @(negedge mclk);
      q.push_back({chk, p_tx});
      op(2, tx);
      if (coll) begin
         repeat (20) @(negedge mclk);
         op(2, ~tx);
      end
      wait_for(1'h0);
      p_sel_n = 1'h1;
      `CHK("peer byte", tx, p_rx)
      `CHK("sck half period", hv[k / 2], gap)
      `CHK("sck idle", clock_polarity, sck_out)
   endtask
   // bench acts as master toward the slave port
   task automatic sbyte(input [7:0] b);
      int i;
      ss_n_in = 1'h0;
      repeat (6) @(negedge mclk);
      for (i = 7; i >= 0; i--) begin
         if (clock_phase)
            m_sck = ~m_sck;
         m_mosi = b[i];
         repeat (6) @(negedge mclk);
         m_sck = ~m_sck;
         got[i] = miso_in;
         repeat (6) @(negedge mclk);
         if (!clock_phase)
            m_sck = ~m_sck;
      end
      repeat (6) @(negedge mclk);
      ss_n_in = 1'h1;
      m_mosi = ~m_mosi;
   endtask
   // monitor: sck spacing and received bytes against notes
   always @(negedge mclk) begin
      gcnt++;
      if (sck_out !== sck_q) begin
         gap = gcnt;
         gcnt = 0;
      end
      sck_q = sck_out;
      if (transfer_done_flag === 1'h1 && done_q !== 1'h1 && q.size() > 0) begin
         note = q.pop_front();
         if (note[8]) `CHK("received byte", note[7:0], port_data_reg)
      end
      done_q = transfer_done_flag;
   end
   // main sequence
   initial begin
      {sys_rst, ss_n_in, p_sel_n} = 3'h7;
      {ctrl_wr, stat_rd, data_wr, data_rd, m_sck, m_mosi, clock_polarity, clock_phase} = 8'h00;
      {ctrl_wdata, data_wdata, p_tx} = 24'h000000;
      void'($urandom(44));
      repeat (5) @(negedge mclk);
      sys_rst = 1'h0;
      @(negedge mclk);
      `CHK("control reset", 8'h00, port_control_reg)
      `CHK("pins released", 3'h7, {sck_oe_n, mosi_oe_n, miso_oe_n})
      for (k = 0; k < 8; k++) begin
         clock_polarity = k[1];
         clock_phase = k[0];
         op(3, {4'h5, clock_polarity, clock_phase, k[2:1]});
         mxfer(k[2], k == 4);
         if (k == 4) `CHK("collision", 1'h1, write_collision_flag)
         if (k == 5) begin
            op(2, 8'hA5);
            repeat (40) @(negedge mclk);
            `CHK("sck quiet", 1'h1, gcnt > 40)
         end
         op(0, 8'h00);
         op(1, 8'h00);
         `CHK("done cleared", 1'h0, transfer_done_flag)
         `CHK("collision cleared", 1'h0, write_collision_flag)
      end
      op(3, 8'hD0);
      ss_n_in = 1'h0;
      wait_for(1'h1);
      @(negedge mclk);
      `CHK("control after fault", 8'h80, port_control_reg)
      `CHK("irq", 1'h1, port_irq)
      ss_n_in = 1'h1;
      op(0, 8'h00);
      op(3, 8'h00);
      `CHK("fault cleared", 1'h0, mode_fault_flag)
      for (j = 0; j < 2; j++) begin
         clock_polarity = j[0];
         clock_phase = j[0];
         m_sck = clock_polarity;
         op(3, {4'h4, clock_polarity, clock_phase, 2'($urandom)});
         tx = 8'($urandom);
         ptx = 8'($urandom);
         op(2, tx);
         q.push_back({1'h1, ptx});
         sbyte(ptx);
         wait_for(1'h0);
         `CHK("slave sent", tx, got)
         if (j == 0) begin
            sbyte(~ptx);
            `CHK("overrun buffer", ptx, port_data_reg)
         end
         op(0, 8'h00);
         op(1, 8'h00);
      end
      `CHK("notes pending", 0, q.size())
      results();
   end
endmodule

/* File: smp_port_properties.sv */
`timescale 1ns/1ps
module smp_port_properties (
   // clock and reset
   input wire       mclk,
   input wire       sys_rst,
   // strobes and state
   input wire       data_wr,
   input wire       data_rd,
   input wire [7:0] port_control_reg,
   input wire       transfer_done_flag,
   input wire       write_collision_flag,
   input wire       mode_fault_flag,
   // pins
   input wire       ss_n_in,
   input wire       sck_out,
   input wire       sck_oe_n,
   input wire       mosi_oe_n,
   input wire       miso_oe_n
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   // role decode
   wire en_m = port_control_reg[6] & port_control_reg[4];
   wire en_s = port_control_reg[6] & ~port_control_reg[4];
   property p_rst;
      $fell(sys_rst) |-> port_control_reg == 8'h00 && !transfer_done_flag
         && !write_collision_flag && !mode_fault_flag;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_flt_clr;
      $rose(mode_fault_flag) |-> ##[0:1] !port_control_reg[6]
         && !port_control_reg[4];
   endproperty
   a_flt_clr: assert property (p_flt_clr) else $error("fault ctl");
   property p_flt_why;
      $rose(mode_fault_flag) |-> $past(en_m);
   endproperty
   a_flt_why: assert property (p_flt_why) else $error("fault cause");
   property p_idle;
      $rose(transfer_done_flag) && port_control_reg[4]
         |-> ##[0:1] sck_out == port_control_reg[3];
   endproperty
   a_idle: assert property (p_idle) else $error("sck idle");
   property p_msdir;
      en_m [*2] |-> !sck_oe_n && !mosi_oe_n && miso_oe_n;
   endproperty
   a_msdir: assert property (p_msdir) else $error("master pins");
   property p_sldir;
      en_s [*2] |-> sck_oe_n && mosi_oe_n;
   endproperty
   a_sldir: assert property (p_sldir) else $error("slave pins");
   property p_rel;
      ss_n_in [*6] |-> miso_oe_n;
   endproperty
   a_rel: assert property (p_rel) else $error("miso driven");
   property p_coll;
      $rose(write_collision_flag) |-> $past(data_wr);
   endproperty
   a_coll: assert property (p_coll) else $error("collision cause");
   property p_clr;
      $fell(transfer_done_flag) |-> $past(data_rd || data_wr);
   endproperty
   a_clr: assert property (p_clr) else $error("done cleared");
   c_done: cover property ($rose(transfer_done_flag));
   c_coll: cover property ($rose(write_collision_flag));
   c_flt: cover property ($rose(mode_fault_flag));
endmodule
bind smp_port smp_port_properties chk_u (
   .mclk                 (mclk),
   .sys_rst              (sys_rst),
   .data_wr              (data_wr),
   .data_rd              (data_rd),
   .port_control_reg     (port_control_reg),
   .transfer_done_flag   (transfer_done_flag),
   .write_collision_flag (write_collision_flag),
   .mode_fault_flag      (mode_fault_flag),
   .ss_n_in              (ss_n_in),
   .sck_out              (sck_out),
   .sck_oe_n             (sck_oe_n),
   .mosi_oe_n            (mosi_oe_n),
   .miso_oe_n            (miso_oe_n)
);

/* File: smp_rate_div.v */
`timescale 1ns/1ps
`include "smp_defines.vh"

module smp_rate_div (
   // clock and reset
   input  wire       mclk,
   input  wire       sys_rst,
   // control
   input  wire       run,
   input  wire [1:0] rate,
   // one pulse per sck half period
   output reg        tick
);

   reg [3:0] cnt;
   reg [3:0] half_end;

   // half period length from the rate pair
   always @* begin
      case (rate)
         2'b00:   half_end = `SMP_HALF_DIV2;
         2'b01:   half_end = `SMP_HALF_DIV4;
         2'b10:   half_end = `SMP_HALF_DIV16;
         default: half_end = `SMP_HALF_DIV32;
      endcase
   end

   // free count while running, restarts when stopped
   always @(posedge mclk) begin
      if (sys_rst || !run) begin
         cnt  <= 4'h0;
         tick <= 1'b0;
      end else if (cnt == half_end) begin
         cnt  <= 4'h0;
         tick <= 1'b1;
      end else begin
         cnt  <= cnt + 4'h1;
         tick <= 1'b0;
      end
   end

endmodule

/* File: smp_sync.v */
`timescale 1ns/1ps
`include "smp_defines.vh"

module smp_sync #(
   parameter WIDTH = 4
) (
   // clock and reset
   input  wire             mclk,
   input  wire             sys_rst,
   // asynchronous levels in, synchronised levels out
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1;

   // two flip-flop synchroniser, pins idle high
   always @(posedge mclk) begin
      if (sys_rst) begin
         stage1   <= {WIDTH{1'b1}};
         sync_out <= {WIDTH{1'b1}};
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule
